// ---- qrb_ctrl_model.sv ----
// controller model: pin clocks, command slots and write beats
`timescale 1ns/1ns
`default_nettype none
module qrb_ctrl_model #(
	parameter int AW = 21
) (
	input wire logic i_reset,
	input wire logic i_single,
	output logic o_k,
	output logic o_k_n,
	output logic o_c,
	output logic o_c_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic [AW-1:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_mlo_n,
	output logic o_mhi_n
);
	logic c_raw = 1'b0;
	int kcnt;
	initial begin
		o_k = 1'b0;
		{o_rd_n, o_wr_n, o_mlo_n, o_mhi_n, o_wdata} = 12'hFFF;
		o_addr = {AW{1'b0}};
	end
	always #32 o_k = ~o_k;
	assign o_k_n = ~o_k;
	// output pair trails a quarter period, both high in single clock mode
	always @(o_k) c_raw <= #16 o_k;
	assign o_c = i_single | c_raw;
	assign o_c_n = i_single | ~c_raw;
	always @(posedge o_k or posedge i_reset) kcnt <= i_reset ? 0 : kcnt + 1;
	task automatic op(input bit rd, input logic [AW-1:0] ra, input bit wr,
		input logic [AW-1:0] wa, input logic [31:0] wd, input logic [7:0] wm);
		do @(negedge o_k); while (kcnt[0]);
		o_rd_n <= !rd;
		o_addr <= ra;
		#64;
		o_rd_n <= 1'b1;
		o_wr_n <= !wr;
		o_addr <= wa;
		#48;
		// returns early so the next command can follow seamlessly
		fork
			beats(wd, wm);
		join_none
	endtask
	// beats centred on each input clock edge
	task automatic beats(input logic [31:0] wd, input logic [7:0] wm);
		#16;
		o_wr_n <= 1'b1;
		for (int b = 0; b < 4; b++) begin
			#16;
			{o_mhi_n, o_mlo_n, o_wdata} <= {wm[2*b+1], wm[2*b], wd[8*b +: 8]};
			#16;
		end
	endtask
endmodule // qrb_ctrl_model
`default_nettype wire

// ---- qrb_defs.svh ----
// constants of the quad-rate burst-of-four sram port
`ifndef QRB_DEFS_SVH
`define QRB_DEFS_SVH
`define QRB_ADDR_W 21
`define QRB_DATA_W 8
`define QRB_BURST_LEN 4
`define QRB_CNT_W 2
`define QRB_NIB_W 4
`define QRB_NIB_LO_LSB 0
`define QRB_NIB_HI_LSB 4
`define QRB_CLK_K 0
`define QRB_CLK_KN 1
`define QRB_CLK_C 2
`define QRB_CLK_CN 3
`define QRB_SYNC_CNT_CAPTURE 2'h2
`define QRB_SYNC_CNT_DONE 2'h3
`define QRB_LAST_BEAT 2'h3
`define QRB_QUEUE_BEAT 2'h2
`endif

// ---- qrb_mem_array.sv ----
// flip-flop word array with nibble-gated write and asynchronous read
`timescale 1ns/1ns
`default_nettype none
`include "qrb_defs.svh"
module qrb_mem_array #(
	parameter int ADDR_W = `QRB_ADDR_W,
	parameter int DATA_W = `QRB_DATA_W
) (
	input wire logic i_ref_clk,
	input wire logic i_wr_en,
	input wire logic [ADDR_W-1:0] i_wr_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic [1:0] i_wr_nib_en,
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [DATA_W-1:0] o_rd_data
);
	logic [DATA_W-1:0] mem_reg [2**ADDR_W];

	// array contents survive reset, as an sram would
	always_ff @(posedge i_ref_clk) begin
		if (i_wr_en && i_wr_nib_en[0]) begin
			mem_reg[i_wr_addr][`QRB_NIB_LO_LSB +: `QRB_NIB_W] <=
				i_wr_data[`QRB_NIB_LO_LSB +: `QRB_NIB_W];
		end
		if (i_wr_en && i_wr_nib_en[1]) begin
			mem_reg[i_wr_addr][`QRB_NIB_HI_LSB +: `QRB_NIB_W] <=
				i_wr_data[`QRB_NIB_HI_LSB +: `QRB_NIB_W];
		end
	end

	assign o_rd_data = mem_reg[i_rd_addr];
endmodule // qrb_mem_array
`default_nettype wire

// ---- qrb_pkg.sv ----
// types shared by the quad-rate burst-of-four sram port
package qrb_pkg;
	typedef enum logic [1:0] {
		QRB_RD_IDLE = 2'h0,
		QRB_RD_WAIT_KN = 2'h1,
		QRB_RD_WAIT_OUT = 2'h3,
		QRB_RD_BEAT = 2'h2
	} qrb_rd_state_e;
	typedef enum logic {
		QRB_WR_IDLE = 1'h0,
		QRB_WR_BURST = 1'h1
	} qrb_wr_state_e;
endpackage

// ---- qrb_port_assertions.sv ----
// pin-level assertions for the quad-rate sram port
`timescale 1ns/1ns
`default_nettype none
module qrb_port_checker #(
	parameter int DATA_W = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_read_sel_n,
	input wire logic i_dll_off_n,
	input wire logic [DATA_W-1:0] o_rd_data,
	input wire logic o_rd_data_oe,
	input wire logic o_echo_strobe,
	input wire logic o_echo_strobe_n,
	input wire logic o_dll_active
);
	logic [2:0] up_reg;
	logic [5:0] idle_reg;
	logic [7:0] span_reg;
	// cycles since reset, since the last read select, and of the current drive span
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			up_reg <= 3'h0;
			idle_reg <= 6'h0;
			span_reg <= 8'h0;
		end else begin
			up_reg <= up_reg + {2'h0, up_reg != 3'h7};
			idle_reg <= i_read_sel_n ? idle_reg + {5'h0, idle_reg != 6'h3F} : 6'h0;
			span_reg <= o_rd_data_oe ? span_reg + 8'h1 : 8'h0;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	a_echo_pair: assert property (up_reg == 3'h7 |-> o_echo_strobe != o_echo_strobe_n)
		else $error("echo strobes not complementary");
	a_echo_running: assert property (up_reg == 3'h7 |-> ##[1:4] $changed(o_echo_strobe))
		else $error("echo strobe stopped");
	a_dll_off: assert property ($fell(i_dll_off_n) |-> ##[2:4] !o_dll_active)
		else $error("delay loop still active");
	a_dll_on: assert property ($rose(i_dll_off_n) |-> ##[2:4] o_dll_active)
		else $error("delay loop not resumed");
	a_hiz_idle: assert property (idle_reg > 6'h20 |-> !o_rd_data_oe)
		else $error("read data driven with no read");
	a_burst_span: assert property ($fell(o_rd_data_oe) |-> span_reg[3:0] == 4'h0)
		else $error("drive span not whole bursts");
	a_data_on_edge: assert property ($changed(o_rd_data) |->
		$changed(o_echo_strobe) || $changed(o_echo_strobe_n))
		else $error("read data moved off a launch edge");
	a_first_beat: assert property ($rose(o_rd_data_oe) |-> $rose(o_echo_strobe_n))
		else $error("first beat not on negative launch clock");
endmodule // qrb_port_checker
bind qrb_sram_port qrb_port_checker #(.DATA_W(DATA_W)) u_port_chk (.i_ref_clk, .i_reset,
	.i_read_sel_n, .i_dll_off_n, .o_rd_data, .o_rd_data_oe, .o_echo_strobe, .o_echo_strobe_n,
	.o_dll_active);
`default_nettype wire

// ---- qrb_sram_port.sv ----
// device side of a quad-rate burst-of-four sram port, oversampled by i_ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "qrb_defs.svh"
module qrb_sram_port
	import qrb_pkg::*;
#(
	parameter int ADDR_W = `QRB_ADDR_W,
	parameter int DATA_W = `QRB_DATA_W
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_in_clk,
	input wire logic i_in_clk_n,
	input wire logic i_out_clk,
	input wire logic i_out_clk_n,
	input wire logic i_read_sel_n,
	input wire logic i_write_sel_n,
	input wire logic [ADDR_W-1:0] i_address_pins,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic i_nibble_low_mask_n,
	input wire logic i_nibble_high_mask_n,
	input wire logic i_dll_off_n,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_rd_data_oe,
	output logic o_echo_strobe,
	output logic o_echo_strobe_n,
	output logic o_dll_active
);
	localparam int CW = `QRB_CNT_W;

	typedef struct packed {
		logic [3:0] clk_s1;
		logic [3:0] clk_s2;
		logic [3:0] clk_d;
		logic [4:0] ctl_s1;
		logic [4:0] ctl_s2;
		logic [ADDR_W-1:0] addr_s1;
		logic [ADDR_W-1:0] addr_s2;
		logic [DATA_W-1:0] data_s1;
		logic [DATA_W-1:0] data_s2;
		logic [1:0] init_cnt;
		logic single_clk;
		logic slot;
		qrb_wr_state_e wr_state;
		logic [CW-1:0] wr_cnt;
		logic [ADDR_W-1:0] wr_base;
		logic wr_q_valid;
		logic [ADDR_W-1:0] wr_q_base;
		qrb_rd_state_e rd_state;
		logic [CW-1:0] rd_cnt;
		logic [ADDR_W-1:0] rd_base;
		logic rd_q_valid;
		logic rd_q_armed;
		logic [ADDR_W-1:0] rd_q_base;
		logic rd_tail;
		logic [DATA_W-1:0] q;
		logic q_oe;
		logic echo;
		logic echo_n;
		logic dll_on;
	} qrb_state_s;

	qrb_state_s st_reg;
	qrb_state_s st_next;
	logic mem_wr_en;
	logic [ADDR_W-1:0] mem_wr_addr;
	logic [1:0] mem_nib_en;
	logic [ADDR_W-1:0] mem_rd_addr;
	logic [DATA_W-1:0] mem_rd_data;

	// 2-bit linear wrap inside the aligned group of four
	function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
		input logic [CW-1:0] cnt);
		logic [CW-1:0] low;
		low = base[CW-1:0] + cnt;
		return {base[ADDR_W-1:CW], low};
	endfunction

	// ctl bit order: {read_sel_n, write_sel_n, high_mask_n, low_mask_n, dll_off_n}
	always_comb begin
		logic [3:0] rise;
		logic k_rise;
		logic kn_rise;
		logic op_rise;
		logic on_rise;
		logic beat;
		logic rd_sel_n;
		logic wr_sel_n;
		logic armed;
		rise = 4'h0;
		k_rise = 1'b0;
		kn_rise = 1'b0;
		op_rise = 1'b0;
		on_rise = 1'b0;
		beat = 1'b0;
		rd_sel_n = 1'b1;
		wr_sel_n = 1'b1;
		armed = 1'b0;
		st_next = st_reg;
		mem_wr_en = 1'b0;
		mem_wr_addr = burst_addr(st_reg.wr_base, st_reg.wr_cnt);
		mem_nib_en = 2'h0;
		mem_rd_addr = burst_addr(st_reg.rd_base, st_reg.rd_cnt);

		// pins come from foreign clocks: two flops before any use
		st_next.clk_s1 = {i_out_clk_n, i_out_clk, i_in_clk_n, i_in_clk};
		st_next.clk_s2 = st_reg.clk_s1;
		st_next.clk_d = st_reg.clk_s2;
		st_next.ctl_s1 = {i_read_sel_n, i_write_sel_n, i_nibble_high_mask_n,
			i_nibble_low_mask_n, i_dll_off_n};
		st_next.ctl_s2 = st_reg.ctl_s1;
		st_next.addr_s1 = i_address_pins;
		st_next.addr_s2 = st_reg.addr_s1;
		st_next.data_s1 = i_wr_data;
		st_next.data_s2 = st_reg.data_s1;

		// no edges until the whole sync chain holds pin samples, else a high pin fakes a rise
		if (st_reg.init_cnt == `QRB_SYNC_CNT_DONE) begin
			rise = st_reg.clk_s2 & ~st_reg.clk_d;
		end
		k_rise = rise[`QRB_CLK_K];
		kn_rise = rise[`QRB_CLK_KN];
		rd_sel_n = st_reg.ctl_s2[4];
		wr_sel_n = st_reg.ctl_s2[3];

		// output pair tied high at start-up selects single clock mode for good
		if (st_reg.init_cnt != `QRB_SYNC_CNT_DONE) begin
			st_next.init_cnt = st_reg.init_cnt + 2'h1;
			if (st_reg.init_cnt == `QRB_SYNC_CNT_CAPTURE) begin
				st_next.single_clk = st_reg.clk_s2[`QRB_CLK_C] & st_reg.clk_s2[`QRB_CLK_CN];
			end
		end
		op_rise = st_reg.single_clk ? k_rise : rise[`QRB_CLK_C];
		on_rise = st_reg.single_clk ? kn_rise : rise[`QRB_CLK_CN];

		st_next.echo = st_reg.single_clk ? st_reg.clk_s2[`QRB_CLK_K] :
			st_reg.clk_s2[`QRB_CLK_C];
		st_next.echo_n = st_reg.single_clk ? st_reg.clk_s2[`QRB_CLK_KN] :
			st_reg.clk_s2[`QRB_CLK_CN];
		st_next.dll_on = st_reg.ctl_s2[0];

		if (k_rise) begin
			st_next.slot = ~st_reg.slot;
		end

		// write beat on every input clock edge
		// first beat on next input rise
		if (st_reg.wr_state == QRB_WR_BURST &&
			(st_reg.wr_cnt[0] ? kn_rise : k_rise)) begin
			mem_wr_en = 1'b1;
			mem_nib_en = ~st_reg.ctl_s2[2:1];
			st_next.wr_cnt = st_reg.wr_cnt + 2'h1;
			if (st_reg.wr_cnt == `QRB_LAST_BEAT) begin
				if (st_reg.wr_q_valid) begin
					st_next.wr_base = st_reg.wr_q_base;
					st_next.wr_q_valid = 1'b0;
				end else begin
					st_next.wr_state = QRB_WR_IDLE;
				end
			end
		end
		if (k_rise && st_reg.slot && !wr_sel_n) begin
			if (st_reg.wr_state == QRB_WR_IDLE) begin
				st_next.wr_state = QRB_WR_BURST;
				st_next.wr_cnt = '0;
				st_next.wr_base = st_reg.addr_s2;
			end else if (st_reg.wr_cnt == `QRB_QUEUE_BEAT && !st_reg.wr_q_valid) begin
				st_next.wr_q_valid = 1'b1;
				st_next.wr_q_base = st_reg.addr_s2;
			end
		end

		// read side runs independently of the write side
		// concurrent ports
		armed = st_reg.rd_q_armed | kn_rise;
		if (kn_rise && st_reg.rd_q_valid) begin
			st_next.rd_q_armed = 1'b1;
		end
		case (st_reg.rd_state)
			QRB_RD_IDLE: begin
				st_next.rd_state = QRB_RD_IDLE;
			end
			// wait for negative input edge, then negative output edge
			QRB_RD_WAIT_KN: begin
				if (kn_rise) begin
					st_next.rd_state = QRB_RD_WAIT_OUT;
				end
			end
			QRB_RD_WAIT_OUT: begin
				if (on_rise) begin
					beat = 1'b1;
					st_next.rd_state = QRB_RD_BEAT;
				end
			end
			QRB_RD_BEAT: begin
				beat = st_reg.rd_cnt[0] ? op_rise : on_rise;
			end
			default: begin
				st_next.rd_state = QRB_RD_IDLE;
			end
		endcase
		// read beat on every output clock edge
		if (beat) begin
			st_next.q = mem_rd_data;
			st_next.q_oe = 1'b1;
			st_next.rd_tail = 1'b0;
			st_next.rd_cnt = st_reg.rd_cnt + 2'h1;
			// fourth read beat ends the burst
			if (st_reg.rd_cnt == `QRB_LAST_BEAT) begin
				if (st_reg.rd_q_valid) begin
					st_next.rd_base = st_reg.rd_q_base;
					st_next.rd_q_valid = 1'b0;
					st_next.rd_q_armed = 1'b0;
					st_next.rd_state = armed ? QRB_RD_WAIT_OUT : QRB_RD_WAIT_KN;
				end else begin
					st_next.rd_state = QRB_RD_IDLE;
					st_next.rd_tail = 1'b1;
				end
			end
		end else if (st_reg.rd_tail && (op_rise || on_rise)) begin
			// drivers off one output edge after the last beat
			st_next.q_oe = 1'b0;
			st_next.rd_tail = 1'b0;
		end
		if (k_rise && !st_reg.slot && !rd_sel_n) begin
			if (st_reg.rd_state == QRB_RD_IDLE) begin
				st_next.rd_state = QRB_RD_WAIT_KN;
				st_next.rd_cnt = '0;
				st_next.rd_base = st_reg.addr_s2;
			end else if (st_reg.rd_state == QRB_RD_BEAT && !st_reg.rd_q_valid) begin
				st_next.rd_q_valid = 1'b1;
				st_next.rd_q_armed = 1'b0;
				st_next.rd_q_base = st_reg.addr_s2;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	qrb_mem_array #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W)
	) u_array (
		.i_ref_clk(i_ref_clk),
		.i_wr_en(mem_wr_en),
		.i_wr_addr(mem_wr_addr),
		.i_wr_data(st_reg.data_s2),
		.i_wr_nib_en(mem_nib_en),
		.i_rd_addr(mem_rd_addr),
		.o_rd_data(mem_rd_data)
	);

	assign o_rd_data = st_reg.q;
	assign o_rd_data_oe = st_reg.q_oe;
	assign o_echo_strobe = st_reg.echo;
	assign o_echo_strobe_n = st_reg.echo_n;
	assign o_dll_active = st_reg.dll_on;
endmodule // qrb_sram_port
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the quad-rate sram port
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int AW = 10;
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	logic single = 1'b0;
	logic i_dll_off_n = 1'b1;
	logic i_in_clk, i_in_clk_n, i_out_clk, i_out_clk_n, i_read_sel_n, i_write_sel_n;
	logic [AW-1:0] i_address_pins;
	logic [7:0] i_wr_data, o_rd_data;
	logic i_nibble_low_mask_n, i_nibble_high_mask_n, o_rd_data_oe, o_echo_strobe;
	logic o_echo_strobe_n, o_dll_active, echo_q, echo_n_q;
	logic [7:0] got[$], exp_q[$], mem[int];
	int num_errors = 0;
	int compares = 0;
	always #4 i_ref_clk = ~i_ref_clk;
	qrb_sram_port #(.ADDR_W(AW)) i_qrb_sram_port (.i_ref_clk, .i_reset, .i_in_clk, .i_in_clk_n,
		.i_out_clk, .i_out_clk_n, .i_read_sel_n, .i_write_sel_n, .i_address_pins, .i_wr_data,
		.i_nibble_low_mask_n, .i_nibble_high_mask_n, .i_dll_off_n, .o_rd_data, .o_rd_data_oe,
		.o_echo_strobe, .o_echo_strobe_n, .o_dll_active);
	qrb_ctrl_model #(.AW(AW)) u_ctrl (.i_reset, .i_single(single), .o_k(i_in_clk),
		.o_k_n(i_in_clk_n), .o_c(i_out_clk), .o_c_n(i_out_clk_n), .o_rd_n(i_read_sel_n),
		.o_wr_n(i_write_sel_n), .o_addr(i_address_pins), .o_wdata(i_wr_data),
		.o_mlo_n(i_nibble_low_mask_n), .o_mhi_n(i_nibble_high_mask_n));
	// a beat is taken at each echo rise while the outputs are driven
	always @(posedge i_ref_clk) begin
		if (o_rd_data_oe === 1'b1 && ((o_echo_strobe & ~echo_q) | (o_echo_strobe_n & ~echo_n_q)))
			got.push_back(o_rd_data);
		echo_q <= o_echo_strobe;
		echo_n_q <= o_echo_strobe_n;
	end
	task automatic chk(input logic [7:0] act, input logic [7:0] exp);
		compares++;
		if (act !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic do_op(input bit rd, input logic [AW-1:0] ra, input bit wr,
		input logic [AW-1:0] wa, input logic [31:0] wd, input logic [7:0] wm);
		logic [AW-1:0] a;
		for (int b = 0; b < 4; b++) begin
			a = {ra[AW-1:2], ra[1:0] + 2'(b)};
			if (rd) exp_q.push_back(mem[a]);
			a = {wa[AW-1:2], wa[1:0] + 2'(b)};
			if (wr && !wm[2*b]) mem[a][3:0] = wd[8*b +: 4];
			if (wr && !wm[2*b+1]) mem[a][7:4] = wd[8*b+4 +: 4];
		end
		u_ctrl.op(rd, ra, wr, wa, wd, wm);
	endtask
	task automatic drain;
		int n;
		n = 0;
		while (got.size() < exp_q.size() && n < 400) begin
			@(posedge i_ref_clk);
			n++;
		end
		if (got.size() < exp_q.size()) begin
			num_errors++;
			$display("wrong value at %0t: read beats missing", $time);
			finish_test();
		end
		repeat (32) @(posedge i_ref_clk);
		#1;
		chk({7'h0, o_rd_data_oe}, 8'h00);
		chk(8'(got.size()), 8'(exp_q.size()));
		while (exp_q.size() > 0 && got.size() > 0)
			chk(got.pop_front(), exp_q.pop_front());
		got.delete();
		exp_q.delete();
	endtask
	// write starts mid-group so the word address wraps
	task automatic t_wrap;
		do_op(1'b0, 10'h000, 1'b1, 10'h006, 32'h44332211, 8'h00);
		drain();
		do_op(1'b1, 10'h004, 1'b0, 10'h000, 32'h00000000, 8'hFF);
		drain();
	endtask
	task automatic t_masks;
		do_op(1'b0, 10'h000, 1'b1, 10'h010, 32'h00000000, 8'h00);
		do_op(1'b0, 10'h000, 1'b1, 10'h010, 32'hAAAAAAAA, 8'hE4);
		drain();
		do_op(1'b1, 10'h010, 1'b0, 10'h000, 32'h00000000, 8'hFF);
		drain();
	endtask
	// read and write in one period, then a seamless read of the fresh words
	task automatic t_overlap;
		do_op(1'b1, 10'h004, 1'b1, 10'h3F8, 32'h5A6B7C8D, 8'h00);
		do_op(1'b1, 10'h3F8, 1'b0, 10'h000, 32'h00000000, 8'hFF);
		drain();
	endtask
	task automatic t_dll;
		@(posedge i_ref_clk);
		#1;
		i_dll_off_n = 1'b0;
		repeat (5) @(posedge i_ref_clk);
		#1;
		chk({7'h0, o_dll_active}, 8'h00);
		i_dll_off_n = 1'b1;
		repeat (5) @(posedge i_ref_clk);
		#1;
		chk({7'h0, o_dll_active}, 8'h01);
	endtask
	// mode is fixed at reset, so reset again with the output pair held high
	task automatic t_single;
		@(negedge i_in_clk);
		@(posedge i_ref_clk);
		#1;
		single = 1'b1;
		i_reset = 1'b1;
		repeat (2) @(posedge i_ref_clk);
		#1;
		i_reset = 1'b0;
		mem.delete();
		do_op(1'b0, 10'h000, 1'b1, 10'h3F1, 32'h0F1E2D3C, 8'h00);
		drain();
		// back-to-back reads take the armed queue path of single clock mode
		do_op(1'b1, 10'h3F0, 1'b0, 10'h000, 32'h00000000, 8'hFF);
		do_op(1'b1, 10'h3F2, 1'b0, 10'h000, 32'h00000000, 8'hFF);
		drain();
	endtask
	initial begin
		repeat (2) @(posedge i_ref_clk);
		#1;
		chk({4'h0, o_rd_data_oe, o_echo_strobe, o_echo_strobe_n, o_dll_active}, 8'h00);
		i_reset = 1'b0;
		t_wrap();
		t_masks();
		t_overlap();
		t_dll();
		t_single();
		finish_test();
	end
endmodule // testbench
`default_nettype wire
